/* core/dmabm_core.sv */
// Summary of operation
// RL1: Byte order bit 1 swaps data buffer bytes to big endian, never descriptors.
// RL2: Five-bit gap field adds that many doublewords between consecutive descriptors.
// RL3: Priority bit 0 grants receive first, 1 grants transmit first.
// RL4: Writing soft reset 1 resets all internal DMA state.
// RL5: Soft reset bit clears itself when the reset sequence ends.
// RL6: Software halts both DMA processes before writing bus-mode fields.
// RL7: Any write to poll register while suspended fetches the transmit descriptor; the code ignores writes with wb_sel_i zero or during soft reset.
// RL8: Descriptor owned by device moves transmit from suspended to running.
// RL9: Software writes the poll register only while transmit is suspended.
// RL10: Poll register is 32 bits wide and resets to the printed default.
// RL11: Auto-poll field rechecks ownership every 200, 800 or 1600 us; 00 off.
// RL12: Descriptor still owned by host keeps transmit suspended awaiting next poll.
// RL13: Soft reset returns all bus-mode fields to zero.
`timescale 1ns/1ns
`default_nettype none
module dmabm_core #(
	parameter int unsigned POLL_200_CYC = dmabm_pkg::POLL_200_CYC,
	parameter int unsigned POLL_800_CYC = dmabm_pkg::POLL_800_CYC,
	parameter int unsigned POLL_1600_CYC = dmabm_pkg::POLL_1600_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [dmabm_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Transmit descriptor fetch
	input wire logic [31:0] tx_base_i,
	input wire logic tx_base_load_i,
	output var dmabm_pkg::dmabm_fetch_t fetch_o,
	input wire logic fetch_ack_i,
	input wire logic fetch_own_i,
	output logic tx_active_o,
	input wire logic tx_done_i,
	// DMA arbitration
	input wire logic rx_req_i,
	input wire logic tx_req_i,
	output logic rx_gnt_o,
	output logic tx_gnt_o,
	// DMA data path
	input wire logic dma_valid_i,
	input wire logic dma_is_desc_i,
	input wire logic [31:0] dma_data_i,
	output logic dma_valid_o,
	output logic [31:0] dma_data_o,
	// Reset to the rest of the controller
	output logic soft_reset_o
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	wire rst_n;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************
	// Bus decode
	// ****************************************
	dmabm_pkg::dmabm_mode_t mode_q, mode_d;
	dmabm_pkg::dmabm_tx_state_t state_q, state_d;
	logic [31:0] poll_q;
	logic [31:0] ptr_q;
	logic [dmabm_pkg::SRST_W-1:0] srst_cnt_q;
	logic ack_q;
	logic [31:0] rdat_q;
	dmabm_pkg::dmabm_fetch_t fetch_q;
	logic tx_active_q, rx_gnt_q, tx_gnt_q, dvalid_q, soft_q;
	logic [31:0] ddata_q;

	wire wb_req;
	wire wr_en;
	wire hit_mode, hit_poll, hit_status;
	wire [31:0] wmask, mode_word, mode_new, status_word, rd_mux;
	wire swr_busy, srst_done, mode_wr, swr_start, poll_wr;
	wire auto_tick;
	wire [31:0] swapped;
	wire rx_win, tx_win;
	wire [31:0] next_ptr;

	assign wb_req = wb_cyc_i && wb_stb_i;
	// Writes commit on the edge where the master sees ack
	assign wr_en = wb_req && ack_q && wb_we_i;
	assign hit_mode = wb_adr_i[7:2] == dmabm_pkg::BUS_MODE_ADDR[7:2];
	assign hit_poll = wb_adr_i[7:2] == dmabm_pkg::POLL_ADDR[7:2];
	assign hit_status = wb_adr_i[7:2] == dmabm_pkg::STATUS_ADDR[7:2];
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign mode_word = {13'h0000, mode_q.tap, 9'h000, mode_q.byte_order_select,
		mode_q.gap, mode_q.prio, mode_q.soft_reset_bit};
	assign mode_new = (mode_word & ~wmask) | (wb_dat_i & wmask);
	assign status_word = {26'h0000000, tx_gnt_q, rx_gnt_q, mode_q.soft_reset_bit,
		state_q};
	assign rd_mux = hit_mode ? mode_word :
		hit_poll ? poll_q :
		hit_status ? status_word : 32'h00000000;

	assign swr_busy = mode_q.soft_reset_bit;
	assign srst_done = swr_busy &&
		(srst_cnt_q == dmabm_pkg::SRST_W'(dmabm_pkg::SRST_CYC - 1));
	// Bus-mode writes are dropped while a soft reset is running
	assign mode_wr = wr_en && hit_mode && !swr_busy;
	assign swr_start = mode_wr && mode_new[dmabm_pkg::SWR_BIT];
	assign poll_wr = wr_en && hit_poll && (|wb_sel_i) && !swr_busy;

	// ****************************************
	// Bus slave
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= wb_req && !ack_q;
			if (wb_req && !ack_q && !wb_we_i) begin
				rdat_q <= rd_mux;
			end
		end
	end

	// ****************************************
	// Bus-mode register and soft reset
	// ****************************************
	always_comb begin
		mode_d = mode_q;
		if (swr_busy) begin
			if (srst_done) begin
				mode_d = '0; // [RL5]
			end
		end else if (swr_start) begin
			mode_d = '0; // [RL13]
			mode_d.soft_reset_bit = 1'b1; // [RL4]
		end else if (mode_wr) begin
			mode_d.tap = mode_new[dmabm_pkg::TAP_MSB:dmabm_pkg::TAP_LSB];
			mode_d.byte_order_select = mode_new[dmabm_pkg::BLE_BIT];
			mode_d.gap = mode_new[dmabm_pkg::GAP_MSB:dmabm_pkg::GAP_LSB];
			mode_d.prio = mode_new[dmabm_pkg::PRIO_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= '0;
			srst_cnt_q <= '0;
		end else begin
			mode_q <= mode_d;
			srst_cnt_q <= swr_busy ? srst_cnt_q + 1'b1 : '0;
		end
	end

	// Poll register: stores any write outside soft reset, restored by soft reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_q <= dmabm_pkg::POLL_RESET;
		end else if (swr_busy) begin
			poll_q <= dmabm_pkg::POLL_RESET; // [RL10]
		end else if (poll_wr) begin
			poll_q <= (poll_q & ~wmask) | (wb_dat_i & wmask);
		end
	end

	// ****************************************
	// Transmit process
	// ****************************************
	dmabm_poll_timer #(
		.P200(POLL_200_CYC),
		.P800(POLL_800_CYC),
		.P1600(POLL_1600_CYC)
	) u_poll_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.restart(swr_busy || (state_q != dmabm_pkg::TX_SUSP)),
		.interval(mode_q.tap), // [RL11]
		.tick(auto_tick)
	);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dmabm_pkg::TX_SUSP: begin
				// Poll writes in other states are ignored
				if (poll_wr || auto_tick) begin
					state_d = dmabm_pkg::TX_FETCH; // [RL7] [RL11]
				end
			end
			dmabm_pkg::TX_FETCH: begin
				if (fetch_ack_i) begin
					state_d = fetch_own_i ? dmabm_pkg::TX_RUN // [RL8]
						: dmabm_pkg::TX_SUSP; // [RL12]
				end
			end
			dmabm_pkg::TX_RUN: begin
				if (tx_done_i) begin
					state_d = dmabm_pkg::TX_FETCH;
				end
			end
			default: begin
				state_d = dmabm_pkg::TX_SUSP;
			end
		endcase
		// Suspend on the committing edge too, so nothing new starts
		if (swr_busy || swr_start) begin
			state_d = dmabm_pkg::TX_SUSP; // [RL4]
		end
	end

	assign next_ptr = ptr_q + dmabm_pkg::DESC_BYTES +
		{25'h0000000, mode_q.gap, 2'b00}; // [RL2]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dmabm_pkg::TX_SUSP;
			ptr_q <= 32'h00000000;
			fetch_q <= '0;
			tx_active_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (swr_busy) begin
				ptr_q <= 32'h00000000;
			end else if (tx_base_load_i) begin
				ptr_q <= tx_base_i;
			end else if (state_q == dmabm_pkg::TX_RUN && tx_done_i) begin
				ptr_q <= next_ptr;
			end
			fetch_q.req <= state_d == dmabm_pkg::TX_FETCH;
			fetch_q.addr <= ptr_q;
			tx_active_q <= state_d == dmabm_pkg::TX_RUN;
		end
	end

	// ****************************************
	// Arbitration and byte order
	// ****************************************
	assign rx_win = rx_req_i && (!tx_req_i || !mode_q.prio); // [RL3]
	assign tx_win = tx_req_i && (!rx_req_i || mode_q.prio); // [RL3]

	// Descriptors always keep little-endian order
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_swap
			assign swapped[8*b +: 8] = (mode_q.byte_order_select && !dma_is_desc_i) ?
				dma_data_i[8*(3-b) +: 8] : dma_data_i[8*b +: 8]; // [RL1]
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_gnt_q <= 1'b0;
			tx_gnt_q <= 1'b0;
			dvalid_q <= 1'b0;
			ddata_q <= 32'h00000000;
			soft_q <= 1'b0;
		end else begin
			rx_gnt_q <= rx_win && !swr_busy;
			tx_gnt_q <= tx_win && !swr_busy;
			dvalid_q <= dma_valid_i && !swr_busy;
			ddata_q <= swapped;
			soft_q <= swr_busy || swr_start;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign fetch_o = fetch_q;
	assign tx_active_o = tx_active_q;
	assign rx_gnt_o = rx_gnt_q;
	assign tx_gnt_o = tx_gnt_q;
	assign dma_valid_o = dvalid_q;
	assign dma_data_o = ddata_q;
	assign soft_reset_o = soft_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_swap;
		dma_valid_i && mode_q.byte_order_select && !dma_is_desc_i && !swr_busy |=>
			dma_data_o == {$past(dma_data_i[7:0]), $past(dma_data_i[15:8]),
			$past(dma_data_i[23:16]), $past(dma_data_i[31:24])};
	endproperty
	a_swap: assert property (p_swap) else $error("data not swapped"); // [RL1]

	property p_gap;
		state_q == dmabm_pkg::TX_RUN && tx_done_i && !tx_base_load_i &&
			!swr_busy |=> ptr_q == $past(ptr_q) + 32'h10 +
			{25'h0, $past(mode_q.gap), 2'b00};
	endproperty
	a_gap: assert property (p_gap) else $error("descriptor gap wrong"); // [RL2]

	property p_prio;
		rx_req_i && tx_req_i && !swr_busy |=>
			tx_gnt_o == $past(mode_q.prio) && rx_gnt_o == !$past(mode_q.prio);
	endproperty
	a_prio: assert property (p_prio) else $error("priority wrong"); // [RL3]

	property p_swr_state;
		swr_start |=> (state_q == dmabm_pkg::TX_SUSP && soft_reset_o) ##1
			(!fetch_o.req && !tx_active_o);
	endproperty
	a_swr_state: assert property (p_swr_state) else $error("no reset"); // [RL4]

	property p_swr_done;
		swr_start |=> mode_q.soft_reset_bit [*8] ##1 !mode_q.soft_reset_bit;
	endproperty
	a_swr_done: assert property (p_swr_done) else $error("swr stuck"); // [RL5]

	property p_poll;
		poll_wr && state_q == dmabm_pkg::TX_SUSP |=>
			state_q == dmabm_pkg::TX_FETCH && fetch_o.req;
	endproperty
	a_poll: assert property (p_poll) else $error("poll ignored"); // [RL7]

	property p_own;
		state_q == dmabm_pkg::TX_FETCH && fetch_ack_i && fetch_own_i &&
			!swr_busy && !swr_start |=> tx_active_o && !fetch_o.req;
	endproperty
	a_own: assert property (p_own) else $error("owned not started"); // [RL8]

	property p_poll_reset;
		$fell(mode_q.soft_reset_bit) |-> poll_q == dmabm_pkg::POLL_RESET;
	endproperty
	a_poll_reset: assert property (p_poll_reset) else $error("poll val"); // [RL10]

	property p_tap_off;
		mode_q.tap == dmabm_pkg::TAP_OFF && state_q == dmabm_pkg::TX_SUSP &&
			!poll_wr |=> state_q == dmabm_pkg::TX_SUSP;
	endproperty
	a_tap_off: assert property (p_tap_off) else $error("spurious poll"); // [RL11]

	property p_not_own;
		state_q == dmabm_pkg::TX_FETCH && fetch_ack_i && !fetch_own_i |=>
			state_q == dmabm_pkg::TX_SUSP && !tx_active_o;
	endproperty
	a_not_own: assert property (p_not_own) else $error("left suspend"); // [RL12]

	property p_fields_zero;
		$fell(mode_q.soft_reset_bit) |-> mode_q == '0;
	endproperty
	a_fields_zero: assert property (p_fields_zero) else $error("fields"); // [RL13]

	property p_cov_swr;
		swr_start ##9 !mode_q.soft_reset_bit;
	endproperty
	c_swr: cover property (p_cov_swr);

	property p_cov_run;
		poll_wr ##[1:20] tx_active_o;
	endproperty
	c_run: cover property (p_cov_run);

	property p_cov_auto;
		auto_tick ##1 fetch_o.req;
	endproperty
	c_auto: cover property (p_cov_auto);

endmodule : dmabm_core
`default_nettype wire

/* core/dmabm_pkg.sv */
package dmabm_pkg;

	// ****************************************
	// Register map and field layout
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] BUS_MODE_ADDR = 8'h00;
	localparam logic [7:0] POLL_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0c;
	localparam int SWR_BIT = 0;
	localparam int PRIO_BIT = 1;
	localparam int GAP_LSB = 2;
	localparam int GAP_MSB = 6;
	localparam int BLE_BIT = 7;
	localparam int TAP_LSB = 17;
	localparam int TAP_MSB = 18;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_STATE_MSB = 2;
	localparam int ST_SWR_BIT = 3;
	localparam int ST_RXG_BIT = 4;
	localparam int ST_TXG_BIT = 5;
	localparam logic [31:0] POLL_RESET = 32'h0fffffff;
	localparam logic [1:0] TAP_OFF = 2'h0;
	localparam logic [1:0] TAP_200 = 2'h1;
	localparam logic [1:0] TAP_800 = 2'h2;
	localparam logic [1:0] TAP_1600 = 2'h3;
	localparam logic [31:0] DESC_BYTES = 32'h00000010;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int NS_PER_US = 1000;
	localparam int POLL_200_US = 200;
	localparam int POLL_800_US = 800;
	localparam int POLL_1600_US = 1600;
	localparam int POLL_200_CYC = POLL_200_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int POLL_800_CYC = POLL_800_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int POLL_1600_CYC = POLL_1600_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int TIMER_W = 19;
	localparam int SRST_NS = 32;
	localparam int SRST_CYC = (SRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SRST_W = 3;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [1:0] tap;
		logic byte_order_select;
		logic [4:0] gap;
		logic prio;
		logic soft_reset_bit;
	} dmabm_mode_t;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
	} dmabm_fetch_t;

	typedef enum logic [2:0] {
		TX_SUSP = 3'b001,
		TX_FETCH = 3'b010,
		TX_RUN = 3'b100
	} dmabm_tx_state_t;

endpackage : dmabm_pkg

/* core/dmabm_poll_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module dmabm_poll_timer #(
	parameter int unsigned P200 = dmabm_pkg::POLL_200_CYC,
	parameter int unsigned P800 = dmabm_pkg::POLL_800_CYC,
	parameter int unsigned P1600 = dmabm_pkg::POLL_1600_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic [1:0] interval,
	// Event
	output logic tick
);
	localparam int W = dmabm_pkg::TIMER_W;

	logic [W-1:0] cnt_q;
	wire [W-1:0] limit;
	wire running;
	wire at_limit;

	assign limit = (interval == dmabm_pkg::TAP_200) ? W'(P200 - 1) :
		(interval == dmabm_pkg::TAP_800) ? W'(P800 - 1) : W'(P1600 - 1);
	assign running = (interval != dmabm_pkg::TAP_OFF) && !restart;
	assign at_limit = cnt_q >= limit;
	assign tick = running && at_limit;

	// Restarted whenever transmit leaves suspend, so each interval is full
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (!running || at_limit) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule : dmabm_poll_timer
`default_nettype wire

/* sim/dmabm_host_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module dmabm_host_mem (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Descriptor fetch from the engine
	input wire dmabm_pkg::dmabm_fetch_t fetch_i,
	output logic fetch_ack_o,
	output logic fetch_own_o,
	// Behaviour chosen by the bench
	input wire logic own_cfg,
	input wire logic [2:0] delay
);
	logic [2:0] cnt_q;
	logic busy_q;

	// ****************************************
	// Memory answer
	// ****************************************
	// One answer per request; owner bit toggles when not valid
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
			busy_q <= 1'b0;
			fetch_ack_o <= 1'b0;
			fetch_own_o <= 1'b0;
		end else begin
			fetch_ack_o <= 1'b0;
			fetch_own_o <= ~fetch_own_o;
			if (!fetch_i.req) begin
				cnt_q <= 3'h0;
				busy_q <= 1'b0;
			end else if (!busy_q && cnt_q == delay) begin
				fetch_ack_o <= 1'b1;
				fetch_own_o <= own_cfg;
				busy_q <= 1'b1;
			end else if (!busy_q) begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end
endmodule : dmabm_host_mem
`default_nettype wire

/* sim/dmabm_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dmabm_core_tb;
	localparam logic [7:0] A_BM = dmabm_pkg::BUS_MODE_ADDR;
	localparam logic [7:0] A_POLL = dmabm_pkg::POLL_ADDR;
	localparam logic [7:0] A_ST = dmabm_pkg::STATUS_ADDR;
	logic core_clk, reset_n, cyc, stb, we, base_ld, tx_done, rx_req, tx_req;
	logic dv, dd, own_cfg, ack, f_ack, f_own, tx_act, rx_gnt, tx_gnt;
	logic dv_o, srst;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rnd, tx_base, ddat, dd_o, rd_o, ex;
	logic [4:0] gap;
	logic [2:0] dly;
	dmabm_pkg::dmabm_fetch_t fetch;
	int n_fail, num_checks;

	dmabm_core #(.POLL_200_CYC(20), .POLL_800_CYC(40), .POLL_1600_CYC(80))
	dut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
		.tx_base_i(tx_base), .tx_base_load_i(base_ld), .fetch_o(fetch),
		.fetch_ack_i(f_ack), .fetch_own_i(f_own), .tx_active_o(tx_act),
		.tx_done_i(tx_done), .rx_req_i(rx_req), .tx_req_i(tx_req),
		.rx_gnt_o(rx_gnt), .tx_gnt_o(tx_gnt), .dma_valid_i(dv),
		.dma_is_desc_i(dd), .dma_data_i(ddat), .dma_valid_o(dv_o),
		.dma_data_o(dd_o), .soft_reset_o(srst));

	dmabm_host_mem mem (.core_clk(core_clk), .rst_n(reset_n),
		.fetch_i(fetch), .fetch_ack_o(f_ack), .fetch_own_o(f_own),
		.own_cfg(own_cfg), .delay(dly));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [31:0] bm(input logic b, input logic [4:0] g,
		input logic p, input logic [1:0] tap);
		return {13'h0, tap, 9'h0, b, g, p, 1'b0};
	endfunction : bm

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge core_clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		rdat = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask : wb

	task automatic wait_on(input int which);
		int i;
		logic v;
		i = 0;
		v = 1'b0;
		while (v !== 1'b1) begin
			@(posedge core_clk);
			v = which == 0 ? fetch.req : (which == 1 ? tx_act : f_ack);
			i++;
			if (i > 300) begin
				n_fail++;
				complete_run();
			end
		end
	endtask : wait_on

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{cyc, stb, we, base_ld, tx_done, rx_req, tx_req, dv, dd} = 9'h0;
		{adr, sel, wdat, tx_base, ddat, own_cfg, dly} = '0;
		sel = 4'hf;
		n_fail = 0;
		num_checks = 0;
		rnd = 32'h880d273b;
		reset_n = 1'b0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		wb(1'b0, A_POLL, 32'h0);
		chk(rdat, dmabm_pkg::POLL_RESET);
		wb(1'b0, A_BM, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
		for (int pass = 0; pass < 2; pass++) begin
			rnd = lfsr(rnd);
			gap = pass ? 5'h1f : rnd[4:0];
			dly = pass ? 3'h7 : rnd[7:5];
			for (int m = 0; m < 2; m++) begin
				wb(1'b1, A_BM, bm(m[0], gap, m[0], 2'h0));
				wb(1'b0, A_BM, 32'h0);
				chk(rdat, bm(m[0], gap, m[0], 2'h0));
				rnd = lfsr(rnd);
				for (int k = 0; k < 2; k++) begin
					@(posedge core_clk);
					dv <= 1'b1;
					dd <= k[0];
					ddat <= rnd;
					@(posedge core_clk);
					dv <= 1'b0;
					@(posedge core_clk);
					ex = (m[0] && !k[0]) ? {rnd[7:0], rnd[15:8],
						rnd[23:16], rnd[31:24]} : rnd;
					chk(dd_o, ex);
					chk({31'h0, dv_o}, 32'h1);
				end
				rx_req <= 1'b1;
				tx_req <= 1'b1;
				repeat (2) @(posedge core_clk);
				chk({30'h0, rx_gnt, tx_gnt}, m[0] ? 32'h1 : 32'h2);
				rx_req <= 1'b0;
				tx_req <= 1'b0;
			end
			tx_base <= {rnd[31:4], 4'h0};
			base_ld <= 1'b1;
			@(posedge core_clk);
			base_ld <= 1'b0;
			own_cfg <= 1'b0;
			wb(1'b1, A_POLL, rnd);
			wait_on(2);
			chk(fetch.addr, tx_base);
			wb(1'b0, A_ST, 32'h0);
			chk({29'h0, rdat[2:0]}, 32'h1);
			wb(1'b0, A_POLL, 32'h0);
			chk(rdat, rnd);
			own_cfg <= 1'b1;
			wb(1'b1, A_POLL, ~rnd);
			wait_on(1);
			chk({30'h0, tx_act, fetch.req}, 32'h2);
			own_cfg <= 1'b0;
			tx_done <= 1'b1;
			@(posedge core_clk);
			tx_done <= 1'b0;
			wait_on(2);
			chk(fetch.addr, tx_base + 32'h10 + {25'h0, gap, 2'h0});
			// Auto-poll: a fresh fetch must come without any poll write
			wb(1'b1, A_BM, bm(1'b0, gap, 1'b0, 2'h1));
			// Interval is 20 cycles here: no fetch may come early
			repeat (15) @(posedge core_clk);
			chk({31'h0, fetch.req}, 32'h0);
			wait_on(0);
			chk({31'h0, fetch.req}, 32'h1);
			wait_on(2);
			wb(1'b1, A_BM, 32'h1);
			wb(1'b0, A_BM, 32'h0);
			chk({31'h0, rdat[0]}, 32'h1);
			chk({31'h0, srst}, 32'h1);
			for (int i = 0; i < 20 && rdat[0]; i++)
				wb(1'b0, A_BM, 32'h0);
			chk(rdat, 32'h0);
			wb(1'b0, A_POLL, 32'h0);
			chk(rdat, dmabm_pkg::POLL_RESET);
		end
		complete_run();
	end
endmodule : dmabm_core_tb
`default_nettype wire
